//--- rtl/pgam_port.sv
// Eight-bit I/O port sharing its pins with the low external address byte
// Notes on behaviour
// - Eight two-way pins, usable as port bits or as low address byte.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Data reads give the latch for output pins, pin level for input pins.
// - Pull-up on only when pull-up bit is 1 and direction bit is 0.
// - Mode 1 drives address on all pins; direction ignores writes, stays all ones.
// - Mode 2: direction 0 is general input, direction 1 drives address bit.
// - Mode 3 is pure general-purpose I/O, no address function.
// - Reset zeroes all three registers; mode 1 sets direction to ones after.
// - Hardware standby floats pins, zeroes data, pull-up; direction too in modes 2, 3.
// - Software standby keeps all registers; port outputs keep driving data.
// - Software standby drives address pins low.
// - Pull-ups only in modes 2 and 3; off in mode 1, reset, hardware standby.
// - Direction at FFB0 write-only; data FFB2 and pull-up FFAC read-write.
//
// Chosen here: the low-address-byte port.
module pgam_port (
	input  wire logic                            clk,
	input  wire logic                            rst,
	input  wire logic [pgam_pkg::MODE_WIDTH-1:0] mode_pins,
	input  wire logic                            hw_standby,
	input  wire logic                            sw_standby,
	input  wire logic [pgam_pkg::PORT_WIDTH-1:0] low_address_byte,
	input  wire logic [pgam_pkg::ADDR_WIDTH-1:0] reg_addr,
	input  wire logic [pgam_pkg::PORT_WIDTH-1:0] reg_wdata,
	input  wire logic                            reg_write,
	input  wire logic                            reg_read,
	output logic      [pgam_pkg::PORT_WIDTH-1:0] reg_rdata,
	input  wire logic [pgam_pkg::PORT_WIDTH-1:0] pin_in,
	output logic      [pgam_pkg::PORT_WIDTH-1:0] pin_out,
	output logic      [pgam_pkg::PORT_WIDTH-1:0] pin_oe,
	output logic      [pgam_pkg::PORT_WIDTH-1:0] pin_pullup
);
	import pgam_pkg::*;

	pgam_pin_if pins ();

	logic [MODE_WIDTH-1:0] mode_sync;
	logic [PORT_WIDTH-1:0] pin_level;
	pgam_mode_t            mode;
	pgam_power_t           power;
	logic [PORT_WIDTH-1:0] direction;
	logic [PORT_WIDTH-1:0] out_data;
	logic [PORT_WIDTH-1:0] pullup_ctl;
	logic                  sel_direction;
	logic                  sel_data;
	logic                  sel_pullup;
	logic [PORT_WIDTH-1:0] next_rdata;

	// Mode pins are straps from outside; they settle two edges after release
	pgam_sync #(
		.WIDTH (MODE_WIDTH)
	) u_mode_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (mode_pins),
		.sync_out (mode_sync)
	);

	pgam_sync #(
		.WIDTH (PORT_WIDTH)
	) u_pin_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (pin_in),
		.sync_out (pin_level)
	);

	assign mode = pgam_decode_mode(mode_sync);

	// Hardware standby outranks software standby
	always_comb begin
		if (hw_standby) begin
			power = PGAM_HW_STANDBY;
		end else if (sw_standby) begin
			power = PGAM_SW_STANDBY;
		end else begin
			power = PGAM_RUN;
		end
	end

	assign sel_direction = (reg_addr == ADDR_DIRECTION);
	assign sel_data      = (reg_addr == ADDR_DATA);
	assign sel_pullup    = (reg_addr == ADDR_PULLUP);

	// Direction register: forced to ones in mode 1, write-only otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			direction <= ALL_ZERO;
		end else if (mode == PGAM_MODE_EXP_NOROM) begin
			direction <= ALL_ONE;
		end else if (power == PGAM_HW_STANDBY) begin
			direction <= ALL_ZERO;
		end else if (reg_write && sel_direction) begin
			direction <= reg_wdata;
		end
	end

	// Data latch: kept in software standby, cleared in hardware standby
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_data <= ALL_ZERO;
		end else if (power == PGAM_HW_STANDBY) begin
			out_data <= ALL_ZERO;
		end else if (reg_write && sel_data) begin
			out_data <= reg_wdata;
		end
	end

	// Pull-up control keeps its value in mode 1; the driver masks it there
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pullup_ctl <= ALL_ZERO;
		end else if (power == PGAM_HW_STANDBY) begin
			pullup_ctl <= ALL_ZERO;
		end else if (reg_write && sel_pullup) begin
			pullup_ctl <= reg_wdata;
		end
	end

	// Read mux; the pin level seen is the synchronised one, two edges old
	always_comb begin
		next_rdata = UNMAPPED_VALUE;
		if (sel_data) begin
			next_rdata = (out_data & direction) | (pin_level & ~direction);
		end else if (sel_pullup) begin
			next_rdata = pullup_ctl;
		end else if (sel_direction) begin
			next_rdata = DIR_READ_VALUE;
		end
	end

	// Read data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= ALL_ZERO;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= ALL_ZERO;
		end
	end

	assign pins.direction        = direction;
	assign pins.out_data         = out_data;
	assign pins.pullup_ctl       = pullup_ctl;
	assign pins.low_address_byte = low_address_byte;
	assign pins.mode             = mode;
	assign pins.power            = power;

	pgam_pin_drive u_drive (
		.clk  (clk),
		.rst  (rst),
		.pins (pins.drive)
	);

	// Straight from the driver's flip-flops
	assign pin_out    = pins.pin_out;
	assign pin_oe     = pins.pin_oe;
	assign pin_pullup = pins.pin_pullup;

endmodule : pgam_port

//--- rtl/pgam_pkg.sv
// Shared constants and types for the address-shared eight-bit I/O port
package pgam_pkg;

	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned ADDR_WIDTH = 16;
	localparam int unsigned MODE_WIDTH = 2;

	// Register addresses on the plain CPU port
	localparam logic [ADDR_WIDTH-1:0] ADDR_PULLUP    = 16'hFFAC;
	localparam logic [ADDR_WIDTH-1:0] ADDR_DIRECTION = 16'hFFB0;
	localparam logic [ADDR_WIDTH-1:0] ADDR_DATA      = 16'hFFB2;

	// Reset and fixed values
	localparam logic [PORT_WIDTH-1:0] ALL_ZERO       = 8'h00;
	localparam logic [PORT_WIDTH-1:0] ALL_ONE        = 8'hFF;
	localparam logic [PORT_WIDTH-1:0] DIR_READ_VALUE = 8'hFF;
	localparam logic [PORT_WIDTH-1:0] UNMAPPED_VALUE = 8'h00;

	// Encodings on the mode pins
	localparam logic [MODE_WIDTH-1:0] MODE_CODE_1 = 2'h1;
	localparam logic [MODE_WIDTH-1:0] MODE_CODE_2 = 2'h2;
	localparam logic [MODE_WIDTH-1:0] MODE_CODE_3 = 2'h3;

	typedef enum logic [1:0] {
		PGAM_MODE_EXP_NOROM,
		PGAM_MODE_EXP_ROM,
		PGAM_MODE_SINGLE
	} pgam_mode_t;

	typedef enum logic [1:0] {
		PGAM_RUN,
		PGAM_SW_STANDBY,
		PGAM_HW_STANDBY
	} pgam_power_t;

	// Code 0 is not a legal mode; treat it as single-chip so no address drives
	function automatic pgam_mode_t pgam_decode_mode(input logic [MODE_WIDTH-1:0] code);
		unique case (code)
			MODE_CODE_1: pgam_decode_mode = PGAM_MODE_EXP_NOROM;
			MODE_CODE_2: pgam_decode_mode = PGAM_MODE_EXP_ROM;
			MODE_CODE_3: pgam_decode_mode = PGAM_MODE_SINGLE;
			default:     pgam_decode_mode = PGAM_MODE_SINGLE;
		endcase
	endfunction : pgam_decode_mode

endpackage : pgam_pkg

//--- rtl/pgam_pin_if.sv
// Carrier between the port register file and its pin driver
interface pgam_pin_if;
	import pgam_pkg::*;

	logic [PORT_WIDTH-1:0] direction;
	logic [PORT_WIDTH-1:0] out_data;
	logic [PORT_WIDTH-1:0] pullup_ctl;
	logic [PORT_WIDTH-1:0] low_address_byte;
	pgam_mode_t            mode;
	pgam_power_t           power;
	logic [PORT_WIDTH-1:0] pin_out;
	logic [PORT_WIDTH-1:0] pin_oe;
	logic [PORT_WIDTH-1:0] pin_pullup;

	modport regs (
		output direction,
		output out_data,
		output pullup_ctl,
		output low_address_byte,
		output mode,
		output power,
		input  pin_out,
		input  pin_oe,
		input  pin_pullup
	);

	modport drive (
		input  direction,
		input  out_data,
		input  pullup_ctl,
		input  low_address_byte,
		input  mode,
		input  power,
		output pin_out,
		output pin_oe,
		output pin_pullup
	);

endinterface : pgam_pin_if

//--- rtl/pgam_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain
module pgam_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// The first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : pgam_sync

//--- rtl/pgam_pin_drive.sv
// Per-pin drive, enable and pull-up selection, registered onto the pins
module pgam_pin_drive (
	input  wire logic clk,
	input  wire logic rst,
	pgam_pin_if.drive pins
);
	import pgam_pkg::*;

	logic [PORT_WIDTH-1:0] addr_sel;
	logic [PORT_WIDTH-1:0] next_out;
	logic [PORT_WIDTH-1:0] next_oe;
	logic [PORT_WIDTH-1:0] next_pullup;

	always_comb begin
		// Which pins carry the address instead of port data
		unique case (pins.mode)
			PGAM_MODE_EXP_NOROM: addr_sel = ALL_ONE;
			PGAM_MODE_EXP_ROM:   addr_sel = pins.direction;
			PGAM_MODE_SINGLE:    addr_sel = ALL_ZERO;
		endcase
	end

	always_comb begin
		next_oe     = pins.direction;
		next_out    = (pins.out_data & ~addr_sel)
			| (pins.low_address_byte & addr_sel);
		next_pullup = pins.pullup_ctl & ~pins.direction;
		if (pins.mode == PGAM_MODE_EXP_NOROM) begin
			next_pullup = ALL_ZERO;
		end
		unique case (pins.power)
			PGAM_RUN: begin
			end
			PGAM_SW_STANDBY: begin
				// Address pins go low; port outputs keep their data
				next_out = pins.out_data & ~addr_sel;
			end
			PGAM_HW_STANDBY: begin
				next_oe     = ALL_ZERO;
				next_out    = ALL_ZERO;
				next_pullup = ALL_ZERO;
			end
		endcase
	end

	// Pins float with pull-ups off during reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins.pin_out    <= ALL_ZERO;
			pins.pin_oe     <= ALL_ZERO;
			pins.pin_pullup <= ALL_ZERO;
		end else begin
			pins.pin_out    <= next_out;
			pins.pin_oe     <= next_oe;
			pins.pin_pullup <= next_pullup;
		end
	end

endmodule : pgam_pin_drive

//--- verif/pgam_port_sva.sv
// Concurrent checks on the port pins and the register read path
module pgam_port_sva
	import pgam_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [1:0]  mode_pins,
	input wire logic        hw_standby,
	input wire logic        sw_standby,
	input wire logic [7:0]  low_address_byte,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_rdata,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe,
	input wire logic [7:0]  pin_pullup
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Five cycles: reset may drop in the first one, then sync, direction and pins follow
	sequence m1_run;
		(mode_pins == MODE_CODE_1 && !hw_standby)[*5];
	endsequence
	rst_quiet_a: assert property (disable iff (1'b0) rst |-> (pin_oe | pin_pullup) == 8'h00)
		else $error("pins active in reset");
	hw_float_a: assert property (hw_standby |=> (pin_oe | pin_out | pin_pullup) == 8'h00)
		else $error("pins active in hardware standby");
	pull_excl_a: assert property ((pin_pullup & pin_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data without a read");
	dir_read_a: assert property (reg_read && reg_addr == ADDR_DIRECTION |=>
		reg_rdata == DIR_READ_VALUE) else $error("direction read value");
	m1_addr_a: assert property (m1_run ##0 !sw_standby |=> pin_oe == 8'hFF &&
		pin_out == $past(low_address_byte)) else $error("mode 1 address drive");
	m1_sleep_a: assert property (m1_run ##0 sw_standby |=> pin_oe == 8'hFF &&
		pin_out == 8'h00) else $error("address pins not low in standby");
	m1_pull_a: assert property (m1_run |=> pin_pullup == 8'h00)
		else $error("pull-up on in mode 1");
endmodule : pgam_port_sva

bind pgam_port pgam_port_sva u_sva (
	.clk              (clk),
	.rst              (rst),
	.mode_pins        (mode_pins),
	.hw_standby       (hw_standby),
	.sw_standby       (sw_standby),
	.low_address_byte (low_address_byte),
	.reg_addr         (reg_addr),
	.reg_read         (reg_read),
	.reg_rdata        (reg_rdata),
	.pin_out          (pin_out),
	.pin_oe           (pin_oe),
	.pin_pullup       (pin_pullup)
);

//--- verif/pgam_pins_model.sv
// Pads outside the port: own drive, outside source, pull-up or a floating level
module pgam_pins_model (
	input  wire logic       clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output logic      [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drift = 8'h00;
	// A floating pad flips every cycle so a stale level never reads as a match
	always @(posedge clk) drift <= ~drift;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_val[i];
			else if (pin_pullup[i]) pin_in[i] = 1'b1;
			else pin_in[i] = drift[i];
		end
	end
endmodule : pgam_pins_model

//--- verif/pgam_port_test.sv
// Self-checking bench for the address-shared port in its three modes
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module pgam_port_test
	import pgam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 0, hw_standby = 0, sw_standby = 0, reg_write = 0, reg_read = 0;
	logic [1:0]  mode_pins = MODE_CODE_3;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, low_address_byte = 8'h96, ext_val = 8'h5A, ext_en = 8'hFF;
	logic [7:0]  reg_rdata, pin_in, pin_out, pin_oe, pin_pullup;
	int          fails = 0, checks = 0, cycles = 0;
	always #4 clk = ~clk;
	pgam_port u_dut (
		.clk              (clk),
		.rst              (rst),
		.mode_pins        (mode_pins),
		.hw_standby       (hw_standby),
		.sw_standby       (sw_standby),
		.low_address_byte (low_address_byte),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_write        (reg_write),
		.reg_read         (reg_read),
		.reg_rdata        (reg_rdata),
		.pin_in           (pin_in),
		.pin_out          (pin_out),
		.pin_oe           (pin_oe),
		.pin_pullup       (pin_pullup)
	);
	pgam_pins_model u_pins (
		.clk        (clk),
		.pin_out    (pin_out),
		.pin_oe     (pin_oe),
		.pin_pullup (pin_pullup),
		.ext_val    (ext_val),
		.ext_en     (ext_en),
		.pin_in     (pin_in)
	);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic start(input logic [1:0] m);
		@(posedge clk);
		rst <= 1;
		mode_pins <= m;
		repeat (12) @(posedge clk);
		rst <= 0;
		repeat (6) @(posedge clk);
	endtask : start

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge clk);
		reg_write <= 0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge clk);
		reg_read <= 0;
		#1 `CHK(reg_rdata, e)
	endtask : rdc

	task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
		repeat (3) @(posedge clk);
		#1 `CHK(pin_oe, oe)
		`CHK(pin_out & oe, out)
		`CHK(pin_pullup, pu)
	endtask : pins

	initial begin
		// Raised by a nonblocking write at time zero so the asynchronous reset sees a real edge
		rst <= 1'b1;
		start(MODE_CODE_3);
		rdc(ADDR_DATA, 8'h5A);
		rdc(ADDR_PULLUP, ALL_ZERO);
		rdc(ADDR_DIRECTION, DIR_READ_VALUE);
		rdc(16'hFFAE, UNMAPPED_VALUE);
		wr(ADDR_DATA, 8'h3C);
		wr(ADDR_DIRECTION, 8'h0F);
		wr(ADDR_PULLUP, 8'hF0);
		ext_en <= 8'h00;
		pins(8'h0F, 8'h0C, 8'hF0);
		rdc(ADDR_DATA, 8'hFC);
		rdc(ADDR_PULLUP, 8'hF0);
		sw_standby <= 1;
		pins(8'h0F, 8'h0C, 8'hF0);
		rdc(ADDR_DATA, 8'hFC);
		sw_standby <= 0;
		hw_standby <= 1;
		pins(ALL_ZERO, ALL_ZERO, ALL_ZERO);
		hw_standby <= 0;
		ext_en <= 8'hFF;
		ext_val <= 8'hC3;
		pins(ALL_ZERO, ALL_ZERO, ALL_ZERO);
		rdc(ADDR_DATA, 8'hC3);
		rdc(ADDR_PULLUP, ALL_ZERO);
		$display("test single-chip done");
		start(MODE_CODE_2);
		wr(ADDR_DATA, ALL_ONE);
		wr(ADDR_DIRECTION, 8'hF0);
		pins(8'hF0, 8'h90, ALL_ZERO);
		sw_standby <= 1;
		pins(8'hF0, ALL_ZERO, ALL_ZERO);
		sw_standby <= 0;
		$display("test mode 2 done");
		start(MODE_CODE_1);
		wr(ADDR_DIRECTION, ALL_ZERO);
		wr(ADDR_PULLUP, ALL_ONE);
		pins(ALL_ONE, 8'h96, ALL_ZERO);
		low_address_byte <= 8'h69;
		pins(ALL_ONE, 8'h69, ALL_ZERO);
		rdc(ADDR_DATA, ALL_ZERO);
		sw_standby <= 1;
		pins(ALL_ONE, ALL_ZERO, ALL_ZERO);
		$display("test mode 1 done");
		sw_standby <= 0;
		start(2'h0);
		wr(ADDR_DATA, 8'h05);
		wr(ADDR_DIRECTION, 8'h0F);
		pins(8'h0F, 8'h05, ALL_ZERO);
		$display("test illegal mode code done");
		end_of_test();
	end
endmodule : pgam_port_test
